// ==== ebac_cfg.svh ====
// Constants for the non-volatile byte access controller.
`ifndef EBAC_CFG_SVH
`define EBAC_CFG_SVH

`define EBAC_ADDR_OFS         8'h1A
`define EBAC_DATA_OFS         8'h1B
`define EBAC_CTRL_OFS         8'h40
`define EBAC_CTRL_BANK        1'b1
`define EBAC_BIT_STORE_PERMIT 3
`define EBAC_BIT_STORE_TRIG   2
`define EBAC_BIT_FETCH_PERMIT 1
`define EBAC_BIT_FETCH_TRIG   0
`define EBAC_ADDR_W           5
`define EBAC_DEPTH            32
`define EBAC_BYTE_RST         8'h00
`define EBAC_ADDR_RST         5'h00
`define EBAC_CTRL_RST         4'h0
`define EBAC_READ_LAST        8'h03
`define EBAC_WRITE_TICKS      8'h0A
`define EBAC_CNT_RST          8'h00
`define EBAC_CNT_ONE          8'h01

`endif

// ==== ebac_nv_array.sv ====
// Byte-wide non-volatile storage array with a registered read port.
`timescale 1ns/1ps
`default_nettype none
`include "ebac_cfg.svh"
module ebac_nv_array
(
  input  wire logic                    i_clock,
  input  wire logic                    i_wr_en,
  input  wire logic                    i_rd_en,
  input  wire logic [`EBAC_ADDR_W-1:0] i_addr,
  input  wire logic [7:0]              i_wdata,
  output logic      [7:0]              o_rdata
);
  // Storage keeps its contents across reset, as a non-volatile array would.
  logic [7:0] mem [0:`EBAC_DEPTH-1];

  always_ff @(posedge i_clock)
  begin
    if (i_wr_en)
    begin
      mem[i_addr] <= i_wdata;
    end
    if (i_rd_en)
    begin
      o_rdata <= mem[i_addr];
    end
  end
endmodule // ebac_nv_array
`default_nettype wire

// ==== ebac_pkg.sv ====
// Types shared by the non-volatile byte access controller.
package ebac_pkg;
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'h1,
    ST_READ  = 3'h2,
    ST_WRITE = 3'h4
  } ebac_state_e;
endpackage

// ==== ebac_properties.sv ====
// Port checker for the non-volatile byte access controller.
`timescale 1ns/1ps
`default_nettype none
module ebac_properties
(
  input wire logic       I_CLOCK,
  input wire logic       I_RST,
  input wire logic [7:0] I_SFR_ADDR,
  input wire logic       I_BANK_SELECT,
  input wire logic       I_SFR_WR,
  input wire logic       I_SFR_RD,
  input wire logic [7:0] I_SFR_WDATA,
  input wire logic       I_WRITE_TIMER_TICK,
  input wire logic       I_NV_DONE_IRQ_MASK,
  input wire logic       I_GLOBAL_IRQ_PERMIT,
  input wire logic       I_STACK_FULL,
  input wire logic       I_IRQ_SERVICED,
  input wire logic [7:0] O_SFR_RDATA,
  input wire logic       O_NV_DONE_REQUEST,
  input wire logic       O_VECTOR_CALL,
  input wire logic       O_CLEAR_GLOBAL_IRQ_PERMIT
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  logic is_ctrl;
  logic mapped;
  assign is_ctrl = (I_SFR_ADDR == 8'h40) && I_BANK_SELECT;
  assign mapped  = is_ctrl || (I_SFR_ADDR == 8'h1A) || (I_SFR_ADDR == 8'h1B);
  sequence s_svc; I_IRQ_SERVICED ##1 !I_IRQ_SERVICED; endsequence
  sequence s_pulse; O_CLEAR_GLOBAL_IRQ_PERMIT ##1 !O_CLEAR_GLOBAL_IRQ_PERMIT; endsequence
  property p_unmapped; I_SFR_RD && !mapped |=> O_SFR_RDATA == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_addr_top; I_SFR_RD && I_SFR_ADDR == 8'h1A |=> O_SFR_RDATA[7:5] == 3'h0; endproperty
  a_addr_top: assert property (p_addr_top) else $error("address top bits set");
  property p_ctrl_top; I_SFR_RD && is_ctrl |=> O_SFR_RDATA[7:4] == 4'h0; endproperty
  a_ctrl_top: assert property (p_ctrl_top) else $error("control top bits set");
  property p_permit;
    I_SFR_RD && is_ctrl
    |=> (O_SFR_RDATA[3] || !O_SFR_RDATA[2]) && (O_SFR_RDATA[1] || !O_SFR_RDATA[0]);
  endproperty
  a_permit: assert property (p_permit) else $error("trigger without permit");
  property p_hold; !I_SFR_RD |=> $stable(O_SFR_RDATA); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_vector;
    O_VECTOR_CALL == $past(O_NV_DONE_REQUEST && I_NV_DONE_IRQ_MASK && I_GLOBAL_IRQ_PERMIT
                           && !I_STACK_FULL && !I_IRQ_SERVICED);
  endproperty
  a_vector: assert property (p_vector) else $error("vector call wrong");
  property p_service; s_svc |-> s_pulse; endproperty
  a_service: assert property (p_service) else $error("no permit clear pulse");
  property p_sticky; O_NV_DONE_REQUEST && !I_IRQ_SERVICED |=> O_NV_DONE_REQUEST; endproperty
  a_sticky: assert property (p_sticky) else $error("done flag dropped");
endmodule // ebac_properties
bind ebac_top ebac_properties i_props
(
  .I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_SFR_ADDR(I_SFR_ADDR), .I_BANK_SELECT(I_BANK_SELECT),
  .I_SFR_WR(I_SFR_WR), .I_SFR_RD(I_SFR_RD), .I_SFR_WDATA(I_SFR_WDATA),
  .I_WRITE_TIMER_TICK(I_WRITE_TIMER_TICK), .I_NV_DONE_IRQ_MASK(I_NV_DONE_IRQ_MASK),
  .I_GLOBAL_IRQ_PERMIT(I_GLOBAL_IRQ_PERMIT), .I_STACK_FULL(I_STACK_FULL),
  .I_IRQ_SERVICED(I_IRQ_SERVICED), .O_SFR_RDATA(O_SFR_RDATA),
  .O_NV_DONE_REQUEST(O_NV_DONE_REQUEST), .O_VECTOR_CALL(O_VECTOR_CALL),
  .O_CLEAR_GLOBAL_IRQ_PERMIT(O_CLEAR_GLOBAL_IRQ_PERMIT)
);
`default_nettype wire

// ==== ebac_timer_model.sv ====
// Free-running write timer oscillator, unrelated in phase to the system clock.
`timescale 1ns/1ps
`default_nettype none
module ebac_timer_model
(
  output logic o_tick
);
  initial
  begin
    o_tick = 1'b0;
    #13;
    forever #45 o_tick = ~o_tick;
  end
endmodule // ebac_timer_model
`default_nettype wire

// ==== ebac_top.sv ====
// Non-volatile byte access controller: registers, cycle sequencer and done request.
`timescale 1ns/1ps
`default_nettype none
`include "ebac_cfg.svh"
module ebac_top
(
  input  wire logic       I_CLOCK,
  input  wire logic       I_RST,
  input  wire logic [7:0] I_SFR_ADDR,
  input  wire logic       I_BANK_SELECT,
  input  wire logic       I_SFR_WR,
  input  wire logic       I_SFR_RD,
  input  wire logic [7:0] I_SFR_WDATA,
  input  wire logic       I_WRITE_TIMER_TICK,
  input  wire logic       I_NV_DONE_IRQ_MASK,
  input  wire logic       I_GLOBAL_IRQ_PERMIT,
  input  wire logic       I_STACK_FULL,
  input  wire logic       I_IRQ_SERVICED,
  output logic      [7:0] O_SFR_RDATA,
  output logic            O_NV_DONE_REQUEST,
  output logic            O_VECTOR_CALL,
  output logic            O_CLEAR_GLOBAL_IRQ_PERMIT
);
  ebac_pkg::ebac_state_e           state;
  ebac_pkg::ebac_state_e           next_state;
  logic [`EBAC_ADDR_W-1:0]         nv_byte_address;
  logic [`EBAC_ADDR_W-1:0]         next_nv_byte_address;
  logic [7:0]                      nv_byte_data;
  logic [7:0]                      next_nv_byte_data;
  logic                            store_permit;
  logic                            next_store_permit;
  logic                            store_trig;
  logic                            next_store_trig;
  logic                            fetch_permit;
  logic                            next_fetch_permit;
  logic                            fetch_trig;
  logic                            next_fetch_trig;
  logic [`EBAC_ADDR_W-1:0]         cyc_addr;
  logic [`EBAC_ADDR_W-1:0]         next_cyc_addr;
  logic [7:0]                      cyc_data;
  logic [7:0]                      next_cyc_data;
  logic [7:0]                      cnt;
  logic [7:0]                      next_cnt;
  logic                            tick_meta;
  logic                            tick_sync;
  logic                            tick_prev;
  logic                            nv_done_request;
  logic                            next_nv_done_request;
  logic                            vector_call;
  logic                            next_vector_call;
  logic                            clr_gie;
  logic                            next_clr_gie;
  logic [7:0]                      rdata;
  logic [7:0]                      next_rdata;
  logic                            arr_wr;
  logic                            arr_rd;
  logic [7:0]                      arr_rdata;
  logic                            tick_edge;
  logic                            wr_ctrl;
  logic                            wr_addr;
  logic                            wr_data;
  logic                            write_done;

  function automatic logic hit_ctrl(input logic [7:0] a, input logic bank);
    hit_ctrl = (a == `EBAC_CTRL_OFS) && (bank == `EBAC_CTRL_BANK);
  endfunction

  assign wr_ctrl   = I_SFR_WR && hit_ctrl(I_SFR_ADDR, I_BANK_SELECT);
  assign wr_addr   = I_SFR_WR && (I_SFR_ADDR == `EBAC_ADDR_OFS);
  assign wr_data   = I_SFR_WR && (I_SFR_ADDR == `EBAC_DATA_OFS);
  assign tick_edge = tick_sync && !tick_prev;

  // The write timer runs from another oscillator, so its tick is synchronised first.
  // async write timer
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
    begin
      tick_meta <= 1'b0;
      tick_sync <= 1'b0;
      tick_prev <= 1'b0;
    end
    else
    begin
      tick_meta <= I_WRITE_TIMER_TICK;
      tick_sync <= tick_meta;
      tick_prev <= tick_sync;
    end
  end

  // Sequencer and control register next values.
  always_comb
  begin
    next_state           = state;
    next_cnt             = cnt;
    next_cyc_addr        = cyc_addr;
    next_cyc_data        = cyc_data;
    next_nv_byte_address = nv_byte_address;
    next_nv_byte_data    = nv_byte_data;
    next_store_permit    = store_permit;
    next_store_trig      = store_trig;
    next_fetch_permit    = fetch_permit;
    next_fetch_trig      = fetch_trig;
    arr_wr               = 1'b0;
    arr_rd               = 1'b0;
    write_done           = 1'b0;
    if (wr_addr)
    begin
      next_nv_byte_address = I_SFR_WDATA[`EBAC_ADDR_W-1:0];
    end
    if (wr_data)
    begin
      next_nv_byte_data = I_SFR_WDATA;
    end
    if (wr_ctrl)
    begin
      next_store_permit = I_SFR_WDATA[`EBAC_BIT_STORE_PERMIT];
      next_fetch_permit = I_SFR_WDATA[`EBAC_BIT_FETCH_PERMIT];
      if (I_SFR_WDATA[`EBAC_BIT_STORE_TRIG] && store_permit)
      begin
        next_store_trig = 1'b1;
      end
      if (I_SFR_WDATA[`EBAC_BIT_FETCH_TRIG] && fetch_permit)
      begin
        next_fetch_trig = 1'b1;
      end
      // A trigger never outlives its permit, so control reads never show one alone.
      // permit clear drops trigger
      if (!I_SFR_WDATA[`EBAC_BIT_STORE_PERMIT])
      begin
        next_store_trig = 1'b0;
      end
      if (!I_SFR_WDATA[`EBAC_BIT_FETCH_PERMIT])
      begin
        next_fetch_trig = 1'b0;
      end
    end
    case (state)
      ebac_pkg::ST_IDLE:
      begin
        next_cnt = `EBAC_CNT_RST;
        next_cyc_addr = nv_byte_address;
        next_cyc_data = nv_byte_data;
        // Store wins if software breaks the one-trigger-at-a-time discipline.
        if (store_trig && store_permit)
        begin
          next_state = ebac_pkg::ST_WRITE;
        end
        else if (fetch_trig && fetch_permit)
        begin
          next_state = ebac_pkg::ST_READ;
        end
      end
      ebac_pkg::ST_READ:
      begin
        next_cnt = cnt + `EBAC_CNT_ONE;
        arr_rd = (cnt == `EBAC_CNT_RST);
        if (!fetch_permit)
        begin
          next_fetch_trig = 1'b0;
          next_state      = ebac_pkg::ST_IDLE;
        end
        else if (cnt == `EBAC_READ_LAST)
        begin
          next_nv_byte_data = arr_rdata;
          next_fetch_trig = 1'b0;
          next_state      = ebac_pkg::ST_IDLE;
        end
      end
      ebac_pkg::ST_WRITE:
      begin
        if (!store_permit)
        begin
          next_store_trig = 1'b0;
          next_state      = ebac_pkg::ST_IDLE;
        end
        else if (tick_edge)
        begin
          next_cnt = cnt + `EBAC_CNT_ONE;
          if (next_cnt == `EBAC_WRITE_TICKS)
          begin
            arr_wr     = 1'b1;
            write_done = 1'b1;
            next_store_trig = 1'b0;
            next_state      = ebac_pkg::ST_IDLE;
          end
        end
      end
      default:
      begin
        next_state = ebac_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
    begin
      state           <= ebac_pkg::ST_IDLE;
      cnt             <= `EBAC_CNT_RST;
      cyc_addr        <= `EBAC_ADDR_RST;
      cyc_data        <= `EBAC_BYTE_RST;
      nv_byte_address <= `EBAC_ADDR_RST;
      nv_byte_data    <= `EBAC_BYTE_RST;
      store_permit    <= 1'b0;
      store_trig      <= 1'b0;
      fetch_permit    <= 1'b0;
      fetch_trig      <= 1'b0;
    end
    else
    begin
      state           <= next_state;
      cnt             <= next_cnt;
      cyc_addr        <= next_cyc_addr;
      cyc_data        <= next_cyc_data;
      nv_byte_address <= next_nv_byte_address;
      nv_byte_data    <= next_nv_byte_data;
      store_permit    <= next_store_permit;
      store_trig      <= next_store_trig;
      fetch_permit    <= next_fetch_permit;
      fetch_trig      <= next_fetch_trig;
    end
  end

  // Done request, vector call and register read data.
  always_comb
  begin
    next_nv_done_request = nv_done_request;
    next_clr_gie         = 1'b0;
    if (I_IRQ_SERVICED)
    begin
      next_nv_done_request = 1'b0;
      next_clr_gie         = 1'b1;
    end
    if (write_done)
    begin
      next_nv_done_request = 1'b1;
    end
    next_vector_call = nv_done_request && I_NV_DONE_IRQ_MASK && I_GLOBAL_IRQ_PERMIT
                       && !I_STACK_FULL && !I_IRQ_SERVICED;
    next_rdata = rdata;
    if (I_SFR_RD)
    begin
      if (I_SFR_ADDR == `EBAC_ADDR_OFS)
      begin
        next_rdata = {3'h0, nv_byte_address};
      end
      else if (I_SFR_ADDR == `EBAC_DATA_OFS)
      begin
        next_rdata = nv_byte_data;
      end
      else if (hit_ctrl(I_SFR_ADDR, I_BANK_SELECT))
      begin
        next_rdata = {4'h0, store_permit, store_trig, fetch_permit, fetch_trig};
      end
      else
      begin
        next_rdata = `EBAC_BYTE_RST;
      end
    end
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
    begin
      nv_done_request <= 1'b0;
      vector_call     <= 1'b0;
      clr_gie         <= 1'b0;
      rdata           <= `EBAC_BYTE_RST;
    end
    else
    begin
      nv_done_request <= next_nv_done_request;
      vector_call     <= next_vector_call;
      clr_gie         <= next_clr_gie;
      rdata           <= next_rdata;
    end
  end

  assign O_SFR_RDATA               = rdata;
  assign O_NV_DONE_REQUEST         = nv_done_request;
  assign O_VECTOR_CALL             = vector_call;
  assign O_CLEAR_GLOBAL_IRQ_PERMIT = clr_gie;

  ebac_nv_array u_array
  (
    .i_clock (I_CLOCK),
    .i_wr_en (arr_wr),
    .i_rd_en (arr_rd),
    .i_addr  (cyc_addr),
    .i_wdata (cyc_data),
    .o_rdata (arr_rdata)
  );
endmodule // ebac_top
`default_nettype wire

// ==== ebac_top_test.sv ====
// Self-checking testbench for the non-volatile byte access controller.
`timescale 1ns/1ps
`default_nettype none
module ebac_top_test;
  logic       clk;
  logic       rst;
  logic [7:0] sfr_addr;
  logic       bank;
  logic       wr;
  logic       rd;
  logic [7:0] wdata;
  logic       tick;
  logic       mask;
  logic       gie;
  logic       stack_full;
  logic       serviced;
  logic [7:0] rdata;
  logic       done;
  logic       vec;
  logic       clr_gie;
  logic [8:0] exp_q[$];
  logic [8:0] note;
  logic [7:0] seen;
  logic       look;
  logic [4:0] a;
  logic [7:0] d;
  int         bad_count;
  int         check_count;
  int         seed;
  ebac_top i_dut
  (
    .I_CLOCK(clk), .I_RST(rst), .I_SFR_ADDR(sfr_addr), .I_BANK_SELECT(bank), .I_SFR_WR(wr),
    .I_SFR_RD(rd), .I_SFR_WDATA(wdata), .I_WRITE_TIMER_TICK(tick), .I_NV_DONE_IRQ_MASK(mask),
    .I_GLOBAL_IRQ_PERMIT(gie), .I_STACK_FULL(stack_full), .I_IRQ_SERVICED(serviced),
    .O_SFR_RDATA(rdata), .O_NV_DONE_REQUEST(done), .O_VECTOR_CALL(vec),
    .O_CLEAR_GLOBAL_IRQ_PERMIT(clr_gie)
  );
  ebac_timer_model i_timer (.o_tick(tick));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] dt);
    @(posedge clk);
    #1;
    wr = w;
    rd = !w;
    sfr_addr = ad;
    wdata = dt;
    @(posedge clk);
    #1;
    wr = 1'b0;
    rd = 1'b0;
  endtask
  task automatic rdx(input logic [7:0] ad, input logic [7:0] e, input logic en);
    exp_q.push_back({en, e});
    bus(1'b0, ad, 8'h00);
  endtask
  // Polls one control bit until the hardware clears it, with a bounded count.
  task automatic poll(input int b);
    int n;
    for (n = 0; n < 80; n++)
    begin
      rdx(8'h40, 8'h00, 1'b0);
      @(negedge clk);
      #1;
      if (seen[b] === 1'b0)
        break;
    end
    check({7'h00, seen[b]}, 8'h00);
  endtask
  always @(posedge clk) look <= rd;
  always @(negedge clk)
  begin
    if (look)
    begin
      note = exp_q.pop_front();
      seen = rdata;
      if (note[8])
        check(rdata, note[7:0]);
    end
  end
  initial
  begin
    #2000000;
    bad_count++;
    finish_test();
  end
  initial
  begin
    seed = 44636;
    {rst, wr, rd, sfr_addr, bank, wdata, mask, gie, stack_full, serviced} = {1'b1, 23'h0};
    {bad_count, check_count} = 0;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    rdx(8'h1A, 8'h00, 1'b1);
    rdx(8'h40, 8'h00, 1'b1);
    bank = 1'b1;
    rdx(8'h40, 8'h00, 1'b1);
    rdx(8'h55, 8'h00, 1'b1);
    bus(1'b1, 8'h1A, 8'hFF);
    rdx(8'h1A, 8'h1F, 1'b1);
    bus(1'b1, 8'h40, 8'h05);
    rdx(8'h40, 8'h00, 1'b1);
    $display("Test decode done");
    repeat (4)
    begin
      a = 5'($random(seed));
      d = 8'($random(seed));
      {mask, stack_full} = 2'($random(seed));
      gie = 1'b0;
      bus(1'b1, 8'h1A, {3'h0, a});
      bus(1'b1, 8'h1B, d);
      bus(1'b1, 8'h40, 8'h08);
      bus(1'b1, 8'h40, 8'h0C);
      gie = 1'($random(seed));
      rdx(8'h40, 8'h0C, 1'b1);
      poll(2);
      repeat (3) @(posedge clk);
      #1;
      check({7'h00, done}, 8'h01);
      check({7'h00, vec}, {7'h00, mask & gie & !stack_full});
      serviced = 1'b1;
      @(posedge clk);
      #1;
      serviced = 1'b0;
      check({6'h00, clr_gie, done}, 8'h02);
      bus(1'b1, 8'h40, 8'h00);
      bus(1'b1, 8'h1B, ~d);
      bus(1'b1, 8'h40, 8'h04);
      bus(1'b1, 8'h40, 8'h02);
      bus(1'b1, 8'h40, 8'h03);
      poll(0);
      rdx(8'h1B, d, 1'b1);
      rdx(8'h1A, {3'h0, a}, 1'b1);
    end
    $display("Test store and fetch done");
    finish_test();
  end
endmodule // ebac_top_test
`default_nettype wire
